// ===== otp_calib_regs.svh
// Constants for the one-time-programmable calibration store
`ifndef OTP_CALIB_REGS_SVH
`define OTP_CALIB_REGS_SVH

`define SHADOW_BITS 9
`define TRIM_BITS 5
`define IDENT_BITS 3
`define TRIM_MSB 8
`define TRIM_LSB 4
`define IDENT_MSB 3
`define IDENT_LSB 1
`define SEAL_POS 0
`define SHADOW_RESET 9'h0_00
`define CAL_ENTRY_BYTE 8'h1E
`define FSET_MASK 8'hF8
`define FSET_CODE 8'h20
`define POWER_DOWN_POS 2
`define PWR_MASK 8'hF8
`define PWR_CODE 8'h08
`define CONT_POS 7
`define DATA_POS 0
`define VOP_BITS 7
`define VOP_MAX 7'h7F
`define LOAD_TIME_MS 5
`define CLK_MHZ 200
`define LOAD_CYCLES (`LOAD_TIME_MS * 1000 * `CLK_MHZ)
// Refresh run time, well inside the refresh bound
`define LOAD_RUN_CYCLES 4096
`define CELL_READ_CYCLES 2

`endif

// ===== otp_calib_pkg.sv
// Types shared by the calibration store modules
`default_nettype none
package otp_calib_pkg;
  typedef enum logic [2:0] {
    mode_normal = 3'b001,
    mode_calib = 3'b010,
    mode_off = 3'b100
  } mode_type;
  typedef logic [8:0] shadow_type;
endpackage
`default_nettype wire

// ===== otp_byte_if.sv
// Received byte stream from the serial front end
`default_nettype none
interface otp_byte_if;
  logic valid;
  logic [7:0] data;
  logic dc;
  logic rw;
  modport source(output valid, output data, output dc, output rw);
  modport sink(input valid, input data, input dc, input rw);
endinterface
`default_nettype wire

// ===== otp_serial_rx.sv
// Serial byte receiver sampling the host clock and data pins
`default_nettype none
`include "otp_calib_regs.svh"
module otp_serial_rx (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk_pin,
  input wire logic sdin_pin,
  input wire logic dc_pin,
  input wire logic sce_n_pin,
  otp_byte_if.source rx
);
  logic [2:0] sclk_sync;
  logic [1:0] sdin_sync;
  logic [1:0] dc_sync;
  logic [1:0] sce_n_sync;
  logic [7:0] shifter;
  logic [2:0] bit_count;
  logic byte_ready;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclk_sync <= 3'h0;
      sdin_sync <= 2'h0;
      dc_sync <= 2'h0;
      sce_n_sync <= 2'h3;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk_pin};
      sdin_sync <= {sdin_sync[0], sdin_pin};
      dc_sync <= {dc_sync[0], dc_pin};
      sce_n_sync <= {sce_n_sync[0], sce_n_pin};
    end
  end

  wire rise = sclk_sync[1] & ~sclk_sync[2];
  wire fall = ~sclk_sync[1] & sclk_sync[2];

  always_ff @(posedge core_clk) begin
    if (srst || sce_n_sync[1]) begin
      bit_count <= 3'h0;
      shifter <= 8'h00;
      byte_ready <= 1'b0;
      rx.valid <= 1'b0;
      rx.data <= 8'h00;
      rx.dc <= 1'b0;
    end else begin
      rx.valid <= 1'b0;
      if (rise) begin
        shifter <= {shifter[6:0], sdin_sync[1]};
        bit_count <= bit_count + 3'h1;
        if (bit_count == 3'h7) begin
          byte_ready <= 1'b1;
          rx.data <= {shifter[6:0], sdin_sync[1]};
          rx.dc <= dc_sync[1];
        end
      end else if (fall && byte_ready) begin
        // Byte takes effect on the falling edge after its last bit
        byte_ready <= 1'b0;
        rx.valid <= 1'b1;
      end
    end
  end

  // Serial link has no read direction
  assign rx.rw = 1'b0;
endmodule
`default_nettype wire

// ===== otp_calib.sv
// Shadow register, calibration mode and refresh control of the OTP store
// How it works
// - Reset enables OTP; only the disable command turns it off.
// - Power-down exit or refresh reloads shadow from cells within 5 ms.
// - In calibration mode each received command byte shifts exactly one bit.
// - Reset clears every shadow bit, seal included.
// - Calibration entry refused after reset until a refresh completes.
// - Order: trim bits 4..0, identity bits MSB first, seal last.
// - Seal set makes the entry command ignored.
// - Calibration bytes are data; a byte with D7 low exits.
// - Shift bytes come with command select low; only two bits decoded.
// - D0 is the data bit, shifted on the falling serial clock edge.
// - After disable, OTP commands ignored and fields lose effect.
// - Refresh reload runs while other instructions keep executing.
// - Power-control toggling the generator refreshes, except in power-down.
// - Shifted contents take effect at once.
// - Trim is a signed offset added with saturation.
// - Cells are reached only through the shadow register.
`default_nettype none
`include "otp_calib_regs.svh"
module otp_calib (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk_pin,
  input wire logic sdin_pin,
  input wire logic dc_pin,
  input wire logic sce_n_pin,
  input wire logic disable_cmd,
  input wire otp_calib_pkg::shadow_type cell_data,
  input wire logic [6:0] operating_voltage_setting,
  output otp_calib_pkg::shadow_type shadow,
  output logic cell_read_strobe,
  output logic module_maker_calibration_mode,
  output logic otp_enabled,
  output logic refresh_busy,
  output logic refresh_done,
  output logic seal_armed,
  output logic power_down_flag,
  output logic hv_power_control_bits,
  output logic [2:0] maker_identity_field,
  output logic [6:0] lcd_voltage_code
);
  import otp_calib_pkg::*;

  otp_byte_if rx_bus ();

  otp_serial_rx rx_unit (
    .core_clk(core_clk),
    .srst(srst),
    .sclk_pin(sclk_pin),
    .sdin_pin(sdin_pin),
    .dc_pin(dc_pin),
    .sce_n_pin(sce_n_pin),
    .rx(rx_bus.source)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  mode_type mode;
  mode_type next_mode;
  logic [23:0] load_count;
  logic load_pending;
  logic disable_seen;

  function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] mask,
                                  input logic [7:0] code);
    is_cmd = (b & mask) == code;
  endfunction

  wire cmd_byte = rx_bus.valid & ~rx_bus.dc & ~rx_bus.rw;
  wire normal_cmd = cmd_byte & (mode != mode_calib);
  wire fset_cmd = normal_cmd & is_cmd(rx_bus.data, `FSET_MASK, `FSET_CODE);
  wire pwr_cmd = normal_cmd & is_cmd(rx_bus.data, `PWR_MASK, `PWR_CODE);
  wire entry_cmd = normal_cmd & (rx_bus.data == `CAL_ENTRY_BYTE);
  wire shift_byte = cmd_byte & (mode == mode_calib);
  wire wake_cmd = fset_cmd & power_down_flag & ~rx_bus.data[`POWER_DOWN_POS];
  wire hv_toggle = pwr_cmd & (rx_bus.data[0] != hv_power_control_bits);
  wire refresh_req = hv_toggle & ~power_down_flag;
  wire load_start = (wake_cmd | refresh_req) & (mode != mode_off);

  ////////////////////////////////////////////////////////////////////////
  // Mode control

  always_comb begin
    next_mode = mode;
    case (mode)
      mode_normal: begin
        if (disable_cmd) begin
          next_mode = mode_off;
        end else if (entry_cmd && seal_armed && !shadow[`SEAL_POS]) begin
          next_mode = mode_calib;
        end
      end
      mode_calib: begin
        if (shift_byte && !rx_bus.data[`CONT_POS]) begin
          next_mode = mode_normal;
        end
      end
      mode_off: next_mode = mode_off;
      default: next_mode = mode_normal;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= mode_normal;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      disable_seen <= 1'b0;
    end else if (mode == mode_off) begin
      disable_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power control bits

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_down_flag <= 1'b1;
      hv_power_control_bits <= 1'b0;
    end else begin
      if (fset_cmd) begin
        power_down_flag <= rx_bus.data[`POWER_DOWN_POS];
      end
      if (pwr_cmd) begin
        hv_power_control_bits <= rx_bus.data[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh timing

  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_count <= 24'h00_0000;
      load_pending <= 1'b0;
      refresh_done <= 1'b0;
      seal_armed <= 1'b0;
      cell_read_strobe <= 1'b0;
    end else begin
      refresh_done <= 1'b0;
      cell_read_strobe <= 1'b0;
      if (load_start) begin
        load_count <= 24'(`LOAD_RUN_CYCLES - 1);
        load_pending <= 1'b1;
      end else if (load_pending) begin
        if (load_count == 24'(`CELL_READ_CYCLES)) begin
          cell_read_strobe <= 1'b1;
        end
        if (load_count == 24'h00_0000) begin
          load_pending <= 1'b0;
          refresh_done <= 1'b1;
          seal_armed <= 1'b1;
        end else begin
          load_count <= load_count - 24'h00_0001;
        end
      end
    end
  end

  assign refresh_busy = load_pending;

  ////////////////////////////////////////////////////////////////////////
  // Shadow register

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shadow <= `SHADOW_RESET;
    end else if (shift_byte) begin
      shadow <= {shadow[7:0], rx_bus.data[`DATA_POS]};
    end else if (load_pending && load_count == 24'h00_0000) begin
      shadow <= cell_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effect of the shadow fields

  function automatic logic [6:0] trim_add(input logic [6:0] base, input logic [4:0] trim);
    logic signed [8:0] sum;
    sum = $signed({2'b00, base}) + $signed({{4{trim[4]}}, trim});
    if (sum < 0) begin
      trim_add = 7'h00;
    end else if (sum > $signed({2'b00, `VOP_MAX})) begin
      trim_add = `VOP_MAX;
    end else begin
      trim_add = sum[6:0];
    end
  endfunction

  wire fields_live = ~disable_seen & (mode != mode_off);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lcd_voltage_code <= 7'h00;
      maker_identity_field <= 3'h0;
    end else if (fields_live) begin
      lcd_voltage_code <= trim_add(operating_voltage_setting,
                                   shadow[`TRIM_MSB:`TRIM_LSB]);
      maker_identity_field <= shadow[`IDENT_MSB:`IDENT_LSB];
    end else begin
      lcd_voltage_code <= operating_voltage_setting;
      maker_identity_field <= 3'h0;
    end
  end

  assign module_maker_calibration_mode = (mode == mode_calib);
  assign otp_enabled = (mode != mode_off);
endmodule
`default_nettype wire

// ===== otp_calib_asserts.sv
// Port checker of the calibration store
`default_nettype none
`include "otp_calib_regs.svh"
module otp_calib_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire otp_calib_pkg::shadow_type shadow,
  input wire logic [6:0] operating_voltage_setting,
  input wire logic module_maker_calibration_mode,
  input wire logic otp_enabled,
  input wire logic refresh_busy,
  input wire logic refresh_done,
  input wire logic seal_armed,
  input wire logic power_down_flag,
  input wire logic hv_power_control_bits,
  input wire logic [2:0] maker_identity_field,
  input wire logic [6:0] lcd_voltage_code
);
  import otp_calib_pkg::*;
  logic [23:0] busy_run;
  logic hv_seen;
  logic sleep_seen;
  // Busy cycles since the last refresh trigger
  always_ff @(posedge core_clk) begin
    hv_seen <= hv_power_control_bits;
    sleep_seen <= power_down_flag;
    if (srst || !refresh_busy || hv_seen != hv_power_control_bits
        || (sleep_seen && !power_down_flag)) begin
      busy_run <= 24'h00_0000;
    end else begin
      busy_run <= busy_run + 24'h00_0001;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  sequence s_off;
    !otp_enabled [*3];
  endsequence
  sequence s_still;
    (otp_enabled && $stable(shadow)) [*3];
  endsequence
  chk_reset_clear: assert property ($fell(srst) |-> shadow == 9'h0_00 && otp_enabled)
    else $error("shadow not clear after reset");
  chk_done_pulse: assert property (refresh_done |=> !refresh_done)
    else $error("refresh done longer than one cycle");
  chk_done_arms: assert property (refresh_done |=> seal_armed)
    else $error("refresh did not arm entry");
  chk_entry_gate: assert property ($rose(module_maker_calibration_mode) |->
    $past(seal_armed) && !$past(shadow[0]) && otp_enabled)
    else $error("calibration entered while blocked");
  chk_disable_stays: assert property (!otp_enabled |=> !otp_enabled)
    else $error("disabled store came back");
  chk_off_voltage: assert property (s_off |-> lcd_voltage_code == $past(operating_voltage_setting))
    else $error("trim still applied when disabled");
  chk_off_ident: assert property (s_off |-> maker_identity_field == 3'h0)
    else $error("identity shown when disabled");
  chk_ident_track: assert property (s_still |-> maker_identity_field == shadow[3:1])
    else $error("identity does not follow shadow");
  chk_shift_order: assert property ($changed(shadow) && !refresh_done && !$past(refresh_done)
    && !$past(srst) |-> shadow[8:1] == $past(shadow[7:0]))
    else $error("shadow changed other than by one shift");
  chk_refresh_awake: assert property ($rose(refresh_busy) |-> !power_down_flag)
    else $error("refresh started in power-down");
  chk_load_bound: assert property (busy_run < 24'(`LOAD_CYCLES))
    else $error("refresh ran past its time bound");
endmodule
bind otp_calib otp_calib_asserts i_chk (.core_clk, .srst, .shadow, .operating_voltage_setting,
  .module_maker_calibration_mode, .otp_enabled, .refresh_busy, .refresh_done, .seal_armed,
  .power_down_flag, .hv_power_control_bits, .maker_identity_field, .lcd_voltage_code);
`default_nettype wire

// ===== otp_host_model.sv
// Host side serial command sender
`default_nettype none
module otp_host_model (
  output var logic sclk_pin,
  output var logic sdin_pin,
  output var logic dc_pin,
  output var logic sce_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_pin = 1'b0;
    sdin_pin = 1'b0;
    dc_pin = 1'b1;
    sce_n_pin = 1'b1;
  end
  // Clock stands low between frames, released data line shows the inverse of the last bit
  task automatic send_byte(input logic [7:0] b);
    // Offset keeps pin changes off rising core clock edges
    #0.5;
    sce_n_pin = 1'b0;
    dc_pin = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdin_pin = b[i];
      #24 sclk_pin = 1'b1;
      #24 sclk_pin = 1'b0;
    end
    #24 sce_n_pin = 1'b1;
    sdin_pin = ~b[0];
    dc_pin = 1'b1;
    #48;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the calibration store
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import otp_calib_pkg::*;
  logic core_clk, srst, disable_cmd, sclk_pin, sdin_pin, dc_pin, sce_n_pin;
  logic cell_read_strobe, module_maker_calibration_mode, otp_enabled, refresh_busy;
  logic refresh_done, seal_armed, power_down_flag, hv_power_control_bits;
  shadow_type cell_data, shadow, exp;
  logic [6:0] operating_voltage_setting, lcd_voltage_code;
  logic [2:0] maker_identity_field;
  logic [31:0] r;
  logic [7:0] b;
  int n_fail, checks, cycles, n_strobe;
  integer seed;
  otp_host_model i_host (.sclk_pin, .sdin_pin, .dc_pin, .sce_n_pin);
  otp_calib i_dut (.core_clk, .srst, .sclk_pin, .sdin_pin, .dc_pin, .sce_n_pin, .disable_cmd,
    .cell_data, .operating_voltage_setting, .shadow, .cell_read_strobe,
    .module_maker_calibration_mode, .otp_enabled, .refresh_busy, .refresh_done, .seal_armed,
    .power_down_flag, .hv_power_control_bits, .maker_identity_field, .lcd_voltage_code);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [6:0] exp_lcd(input logic [6:0] v, input logic [4:0] t);
    int s;
    s = int'(v) + int'($signed(t));
    exp_lcd = s < 0 ? 7'h00 : (s > 127 ? 7'h7F : s[6:0]);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] e, input logic [8:0] got);
    checks++;
    if (got !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    i_host.send_byte(c);
    repeat (4) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cell_read_strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
    end
    if (cycles == 20_000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'h1c5d;
    cycles = 0;
    srst = 1'b1;
    disable_cmd = 1'b0;
    cell_data = 9'h0_00;
    operating_voltage_setting = 7'h7D;
    r = $random(seed);
    @(posedge core_clk);
    cell_data <= {r[8:1], 1'b0};
    repeat (15) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("shadow", 9'h0_00, shadow);
    check("enabled", 9'h0_01, 9'(otp_enabled));
    cmd(8'h1E);
    check("early entry", 9'h0_00, 9'(module_maker_calibration_mode));
    cmd(8'h20);
    check("power down", 9'h0_00, 9'(power_down_flag));
    cmd(8'h09);
    cmd(8'h08);
    check("hv", 9'h0_00, 9'(hv_power_control_bits));
    check("busy", 9'h0_01, 9'(refresh_busy));
    wait (refresh_done === 1'b1);
    repeat (2) @(posedge core_clk);
    check("loaded", cell_data, shadow);
    check("strobe", 9'h0_01, 9'(n_strobe));
    check("armed", 9'h0_01, 9'(seal_armed));
    exp = shadow;
    cmd(8'h1E);
    check("entry", 9'h0_01, 9'(module_maker_calibration_mode));
    for (int i = 0; i < 9; i++) begin
      r = $random(seed);
      b = {i < 8, 1'b0, r[5:1], i == 8 ? 1'b1 : r[0]};
      exp = {exp[7:0], b[0]};
      cmd(b);
      check("shadow shift", exp, shadow);
    end
    check("exit", 9'h0_00, 9'(module_maker_calibration_mode));
    check("lcd", 9'(exp_lcd(7'h7D, exp[8:4])), 9'(lcd_voltage_code));
    check("ident", 9'(exp[3:1]), 9'(maker_identity_field));
    operating_voltage_setting <= 7'h00;
    repeat (3) @(posedge core_clk);
    check("lcd low", 9'(exp_lcd(7'h00, exp[8:4])), 9'(lcd_voltage_code));
    operating_voltage_setting <= 7'h7D;
    cmd(8'h1E);
    check("sealed entry", 9'h0_00, 9'(module_maker_calibration_mode));
    disable_cmd <= 1'b1;
    @(posedge core_clk);
    disable_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmd(8'h24);
    check("disabled", 9'h0_00, 9'(otp_enabled));
    check("sleep cmd", 9'h0_01, 9'(power_down_flag));
    cmd(8'h20);
    check("no refresh", 9'h0_00, 9'(refresh_busy));
    check("base lcd", 9'h0_7D, 9'(lcd_voltage_code));
    check("no ident", 9'h0_00, 9'(maker_identity_field));
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("re-enabled", 9'h0_01, 9'(otp_enabled));
    check("cleared", 9'h0_00, shadow);
    tally_and_finish();
  end
endmodule
`default_nettype wire
